//--- ufc_feature_ctrl.sv
// per-channel feature control: bank select, latches, level counters, flow control
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "ufc_regs.svh"

module ufc_feature_ctrl (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] modem_status_in,
  output logic modem_status_read,
  input wire logic [7:0] tx_fifo_space,
  input wire logic [7:0] rx_fifo_fill,
  input wire logic [7:0] rx_trigger_level,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char,
  input wire logic clear_to_send_in,
  output logic tx_halt,
  output logic rts_pin,
  output logic rx_trigger_reached,
  output logic [15:0] baud_divisor,
  output logic [7:0] int_enable,
  output logic [7:0] fifo_ctrl,
  output logic [7:0] modem_ctrl,
  output logic special_char_seen,
  output logic rx_on_match,
  output logic rx_off_match,
  input wire logic tx_send_on,
  input wire logic tx_send_off,
  output logic tx_flow_valid,
  output logic [7:0] tx_flow_char,
  input wire logic tx_flow_ready
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // merge a written byte into a field, only the bits in mask change
  function automatic logic [7:0] merge_bits(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic [7:0] mask);
    merge_bits = (old_v & ~mask) | (new_v & mask);
  endfunction

  // one pair selector: 10 first, 01 second, 11 both, 00 none
  function automatic logic pair_hit(input logic [1:0] sel, input logic [7:0] first_c,
                                    input logic [7:0] second_c, input logic [7:0] ch);
    pair_hit = (sel[1] && ch == first_c) || (sel[0] && ch == second_c);
  endfunction

  ufc_pkg::ufc_state_t cur_ff;
  ufc_pkg::ufc_state_t nxt_ff;

  logic [5:0] word_addr;
  logic [1:0] bank;
  logic lvl_open;
  logic setup_phase;
  logic access_phase;
  logic wr_ok;
  logic [7:0] wbyte;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic enh_open;
  logic [1:0] tx_sel;
  logic [1:0] rx_sel;
  logic both_pairs;
  logic on_first_hit;
  logic on_second_hit;
  logic off_first_hit;
  logic off_second_hit;

  assign word_addr = {paddr[5:2], 2'h0};
  assign bank = cur_ff.bank_select[2:1];
  assign lvl_open = (bank == `UFC_BANK_GENERAL) && cur_ff.bank_select[`UFC_BSEL_LVL_EN];
  assign setup_phase = clk_en && psel && !penable;
  assign access_phase = clk_en && psel && penable;
  assign wr_ok = access_phase && pwrite && pstrb[0] && !cur_ff.pslverr;
  assign wbyte = pwdata[7:0];
  assign enh_open = cur_ff.enhanced_features[`UFC_EFR_ENH_EN];
  assign tx_sel = cur_ff.enhanced_features[3:2];
  assign rx_sel = cur_ff.enhanced_features[1:0];
  assign both_pairs = (tx_sel == 2'h3) && (rx_sel == 2'h3);

  // ---------------------------------------------------------------
  // read decode, per bank
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = `UFC_RST_BYTE;
    rd_hit = 1'b0;
    wr_hit = 1'b0;
    if (paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0) begin
      if (word_addr == `UFC_OFS_MODEM_STATUS) begin
        rd_byte = modem_status_in;
        rd_hit = 1'b1;
        wr_hit = 1'b1;
      end else if (word_addr == `UFC_OFS_SCRATCHPAD) begin
        rd_byte = cur_ff.scratchpad;
        rd_hit = 1'b1;
        wr_hit = 1'b1;
      end else begin
        unique case (bank)
          `UFC_BANK_GENERAL: begin
            unique case (word_addr)
              `UFC_OFS_INT_ENABLE: begin
                rd_byte = cur_ff.int_enable;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_FIFO_CTRL: begin
                rd_byte = cur_ff.fifo_ctrl;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_MODEM_CTRL: begin
                rd_byte = cur_ff.modem_ctrl;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_INT_STATUS: begin
                rd_byte = {2'h0, cur_ff.isr_bit5, cur_ff.special_seen, 4'h0};
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_TX_SPACE: begin
                rd_byte = tx_fifo_space;
                rd_hit = lvl_open;
              end
              `UFC_OFS_RX_FILL: begin
                rd_byte = rx_fifo_fill;
                rd_hit = lvl_open;
              end
              default: begin
                rd_hit = 1'b0;
              end
            endcase
          end
          `UFC_BANK_EXTRA1: begin
            if (word_addr == `UFC_OFS_DIV_LOW) begin
              rd_byte = cur_ff.divisor_low;
              rd_hit = 1'b1;
              wr_hit = 1'b1;
            end else if (word_addr == `UFC_OFS_DIV_HIGH) begin
              rd_byte = cur_ff.divisor_high;
              rd_hit = 1'b1;
              wr_hit = 1'b1;
            end
          end
          `UFC_BANK_EXTRA2: begin
            unique case (word_addr)
              `UFC_OFS_ENH_FEAT: begin
                // auto rts bit reads back only while the hold is engaged
                rd_byte = cur_ff.enhanced_features;
                rd_byte[`UFC_EFR_AUTO_RTS] = cur_ff.enhanced_features[`UFC_EFR_AUTO_RTS]
                                             && cur_ff.rts_hold;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_ON_FIRST: begin
                rd_byte = cur_ff.on_char_first;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_ON_SECOND: begin
                rd_byte = cur_ff.on_char_second;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_OFF_FIRST: begin
                rd_byte = cur_ff.off_char_first;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              `UFC_OFS_OFF_SECOND: begin
                rd_byte = cur_ff.off_char_second;
                rd_hit = 1'b1;
                wr_hit = 1'b1;
              end
              default: begin
                rd_hit = 1'b0;
              end
            endcase
          end
          default: begin
            // reserved bank: reads zero and flags an error
            rd_hit = 1'b0;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // receive character compare
  // ---------------------------------------------------------------
  assign on_first_hit = rx_char == cur_ff.on_char_first;
  assign on_second_hit = rx_char == cur_ff.on_char_second;
  assign off_first_hit = rx_char == cur_ff.off_char_first;
  assign off_second_hit = rx_char == cur_ff.off_char_second;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.rx_on_hit = 1'b0;
    nxt_ff.rx_off_hit = 1'b0;
    // read data is captured in the setup cycle so prdata comes from a flop
    if (setup_phase) begin
      nxt_ff.prdata = {24'h0, pwrite ? `UFC_RST_BYTE : rd_byte};
      nxt_ff.pslverr = pwrite ? !wr_hit : !rd_hit;
    end
    // special character flag clears on read, a match in the same cycle wins
    if (access_phase && !pwrite && !cur_ff.pslverr && bank == `UFC_BANK_GENERAL
        && word_addr == `UFC_OFS_INT_STATUS) begin
      nxt_ff.special_seen = 1'b0;
    end
    if (wr_ok) begin
      if (word_addr == `UFC_OFS_MODEM_STATUS) begin
        nxt_ff.bank_select = wbyte[2:0];
      end else if (word_addr == `UFC_OFS_SCRATCHPAD) begin
        nxt_ff.scratchpad = wbyte;
      end else if (bank == `UFC_BANK_GENERAL) begin
        unique case (word_addr)
          `UFC_OFS_INT_ENABLE: begin
            nxt_ff.int_enable = merge_bits(cur_ff.int_enable, wbyte,
                                  enh_open ? 8'hff : ~`UFC_IER_ENH_MASK);
          end
          `UFC_OFS_FIFO_CTRL: begin
            nxt_ff.fifo_ctrl = merge_bits(cur_ff.fifo_ctrl, wbyte,
                                 enh_open ? 8'hff : ~`UFC_FCR_ENH_MASK);
          end
          `UFC_OFS_MODEM_CTRL: begin
            nxt_ff.modem_ctrl = merge_bits(cur_ff.modem_ctrl, wbyte,
                                  enh_open ? 8'hff : ~`UFC_MCR_ENH_MASK);
          end
          `UFC_OFS_INT_STATUS: begin
            if (enh_open) begin
              nxt_ff.isr_bit5 = wbyte[5];
            end
          end
          default: begin
            nxt_ff.isr_bit5 = cur_ff.isr_bit5;
          end
        endcase
      end else if (bank == `UFC_BANK_EXTRA1) begin
        if (word_addr == `UFC_OFS_DIV_LOW) begin
          nxt_ff.divisor_low = wbyte;
        end else if (word_addr == `UFC_OFS_DIV_HIGH) begin
          nxt_ff.divisor_high = wbyte;
        end
      end else if (bank == `UFC_BANK_EXTRA2) begin
        unique case (word_addr)
          `UFC_OFS_ENH_FEAT: nxt_ff.enhanced_features = wbyte;
          `UFC_OFS_ON_FIRST: nxt_ff.on_char_first = wbyte;
          `UFC_OFS_ON_SECOND: nxt_ff.on_char_second = wbyte;
          `UFC_OFS_OFF_FIRST: nxt_ff.off_char_first = wbyte;
          `UFC_OFS_OFF_SECOND: nxt_ff.off_char_second = wbyte;
          default: nxt_ff.on_char_first = cur_ff.on_char_first;
        endcase
      end
    end

    // auto rts: engage above the trigger, release once below it
    if (!cur_ff.enhanced_features[`UFC_EFR_AUTO_RTS]) begin
      nxt_ff.rts_hold = 1'b0;
    end else if (rx_fifo_fill > rx_trigger_level) begin
      nxt_ff.rts_hold = 1'b1;
    end else if (rx_fifo_fill < rx_trigger_level) begin
      nxt_ff.rts_hold = 1'b0;
    end

    // receive side: special detect and in-band on/off matching
    if (rx_char_valid && clk_en) begin
      if (cur_ff.enhanced_features[`UFC_EFR_SPECIAL] && off_second_hit) begin
        nxt_ff.special_seen = 1'b1;
      end
      if (both_pairs) begin
        // pairs must arrive back to back, first then second
        nxt_ff.rx_on_half = on_first_hit;
        nxt_ff.rx_off_half = off_first_hit;
        nxt_ff.rx_on_hit = cur_ff.rx_on_half && on_second_hit;
        nxt_ff.rx_off_hit = cur_ff.rx_off_half && off_second_hit;
      end else begin
        nxt_ff.rx_on_half = 1'b0;
        nxt_ff.rx_off_half = 1'b0;
        nxt_ff.rx_on_hit = pair_hit(rx_sel, cur_ff.on_char_first,
                                    cur_ff.on_char_second, rx_char);
        nxt_ff.rx_off_hit = pair_hit(rx_sel, cur_ff.off_char_first,
                                     cur_ff.off_char_second, rx_char);
      end
    end

    // transmit side: send one character, or both of a pair in turn
    unique case (cur_ff.tx_state)
      ufc_pkg::TX_IDLE: begin
        if ((tx_send_on || tx_send_off) && tx_sel != 2'h0) begin
          nxt_ff.tx_is_off = tx_send_off;
          nxt_ff.tx_state = ufc_pkg::TX_SEND_A;
          if (tx_send_off) begin
            nxt_ff.tx_char = tx_sel[1] ? cur_ff.off_char_first : cur_ff.off_char_second;
          end else begin
            nxt_ff.tx_char = tx_sel[1] ? cur_ff.on_char_first : cur_ff.on_char_second;
          end
        end
      end
      ufc_pkg::TX_SEND_A: begin
        if (tx_flow_ready) begin
          if (tx_sel == 2'h3) begin
            nxt_ff.tx_state = ufc_pkg::TX_SEND_B;
            nxt_ff.tx_char = cur_ff.tx_is_off ? cur_ff.off_char_second : cur_ff.on_char_second;
          end else begin
            nxt_ff.tx_state = ufc_pkg::TX_IDLE;
          end
        end
      end
      ufc_pkg::TX_SEND_B: begin
        if (tx_flow_ready) begin
          nxt_ff.tx_state = ufc_pkg::TX_IDLE;
        end
      end
      default: begin
        nxt_ff.tx_state = ufc_pkg::TX_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // state register, frozen while the clock enable is low
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_ff <= '0;
      cur_ff.bank_select <= `UFC_RST_BANK;
      cur_ff.enhanced_features <= `UFC_RST_BYTE;
      cur_ff.prdata <= `UFC_RST_WORD;
      cur_ff.tx_state <= ufc_pkg::TX_IDLE;
    end else if (clk_en) begin
      cur_ff <= nxt_ff;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // zero wait state: setup loads the read byte, access completes in any cycle with clk_en high
  assign pready = clk_en;
  assign prdata = cur_ff.prdata;
  assign pslverr = access_phase && cur_ff.pslverr;
  assign modem_status_read = access_phase && !pwrite && word_addr == `UFC_OFS_MODEM_STATUS
                             && paddr[31:6] == 26'h0 && paddr[1:0] == 2'h0;
  assign baud_divisor = {cur_ff.divisor_high, cur_ff.divisor_low};
  assign int_enable = cur_ff.int_enable;
  assign fifo_ctrl = cur_ff.fifo_ctrl;
  assign modem_ctrl = cur_ff.modem_ctrl;
  assign special_char_seen = cur_ff.special_seen;
  assign rx_on_match = cur_ff.rx_on_hit;
  assign rx_off_match = cur_ff.rx_off_hit;
  assign tx_flow_valid = cur_ff.tx_state != ufc_pkg::TX_IDLE;
  assign tx_flow_char = cur_ff.tx_char;
  assign tx_halt = cur_ff.enhanced_features[`UFC_EFR_AUTO_CTS] && clear_to_send_in;
  // pin high asks the peer to stop; the software bit drives it active-high
  assign rts_pin = cur_ff.enhanced_features[`UFC_EFR_AUTO_RTS] ? cur_ff.rts_hold
                   : cur_ff.modem_ctrl[`UFC_MCR_RTS];
  assign rx_trigger_reached = cur_ff.enhanced_features[`UFC_EFR_AUTO_RTS]
                              && rx_fifo_fill >= rx_trigger_level;

endmodule // ufc_feature_ctrl

//--- ufc_regs.svh
// register offsets, field positions, reset values of the feature control block
`ifndef UFC_REGS_SVH
`define UFC_REGS_SVH
// byte offsets, bank 00 (general set)
`define UFC_OFS_MODEM_STATUS 6'h00
`define UFC_OFS_SCRATCHPAD 6'h04
`define UFC_OFS_INT_ENABLE 6'h08
`define UFC_OFS_FIFO_CTRL 6'h0c
`define UFC_OFS_MODEM_CTRL 6'h10
`define UFC_OFS_INT_STATUS 6'h14
`define UFC_OFS_TX_SPACE 6'h18
`define UFC_OFS_RX_FILL 6'h1c
// bank 01 (first extra set)
`define UFC_OFS_DIV_LOW 6'h08
`define UFC_OFS_DIV_HIGH 6'h0c
// bank 10 (second extra set)
`define UFC_OFS_ENH_FEAT 6'h08
`define UFC_OFS_ON_FIRST 6'h0c
`define UFC_OFS_ON_SECOND 6'h10
`define UFC_OFS_OFF_FIRST 6'h14
`define UFC_OFS_OFF_SECOND 6'h18
// bank codes and field positions
`define UFC_BANK_GENERAL 2'h0
`define UFC_BANK_EXTRA1 2'h1
`define UFC_BANK_EXTRA2 2'h2
`define UFC_BSEL_LVL_EN 0
`define UFC_EFR_AUTO_CTS 7
`define UFC_EFR_AUTO_RTS 6
`define UFC_EFR_SPECIAL 5
`define UFC_EFR_ENH_EN 4
`define UFC_ISR_SPECIAL 4
`define UFC_MCR_RTS 1
// write masks of fields guarded by the enhanced enable bit
`define UFC_IER_ENH_MASK 8'hf0
`define UFC_FCR_ENH_MASK 8'h30
`define UFC_MCR_ENH_MASK 8'he0
// reset values
`define UFC_RST_BYTE 8'h00
`define UFC_RST_BANK 3'h0
`define UFC_RST_WORD 32'h0000_0000
`endif

//--- ufc_pkg.sv
// types of the feature control block
package ufc_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND_A, TX_SEND_B} ufc_tx_state_t;
  typedef struct packed {
    logic [2:0] bank_select;
    logic [7:0] scratchpad;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] int_enable;
    logic [7:0] fifo_ctrl;
    logic [7:0] modem_ctrl;
    logic isr_bit5;
    logic special_seen;
    logic [7:0] enhanced_features;
    logic [7:0] on_char_first;
    logic [7:0] on_char_second;
    logic [7:0] off_char_first;
    logic [7:0] off_char_second;
    logic rts_hold;
    logic rx_on_half;
    logic rx_off_half;
    logic rx_on_hit;
    logic rx_off_hit;
    ufc_tx_state_t tx_state;
    logic tx_is_off;
    logic [7:0] tx_char;
    logic [31:0] prdata;
    logic pslverr;
  } ufc_state_t;
endpackage

//--- ufc_feature_ctrl_properties.sv
// assertions on the ports of the feature control block
`timescale 1ns/1ns
module ufc_checker (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] modem_status_in,
  input wire logic modem_status_read,
  input wire logic [7:0] tx_fifo_space,
  input wire logic [7:0] rx_fifo_fill,
  input wire logic clear_to_send_in,
  input wire logic tx_halt,
  input wire logic rts_pin,
  input wire logic [15:0] baud_divisor,
  input wire logic [7:0] int_enable,
  input wire logic [7:0] modem_ctrl
);
  // ----
  // shadow of bank select and feature bits, rebuilt from bus writes
  // ----
  logic [2:0] bank_ff;
  logic [7:0] efr_ff;
  logic [7:0] wbyte;
  logic wr;
  logic rd;
  assign wbyte = pwdata[7:0];
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  assign rd = psel && penable && pready && !pwrite;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_ff <= 3'h0;
      efr_ff <= 8'h00;
    end else begin
      if (wr && paddr == 32'h0) bank_ff <= pwdata[2:0];
      if (wr && paddr == 32'h8 && bank_ff[2:1] == 2'h2) efr_ff <= wbyte;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  a_halt_cts: assert property (tx_halt == (efr_ff[7] && clear_to_send_in))
    else $error("halt does not follow clear to send");
  a_rts_soft: assert property (!efr_ff[6] |-> rts_pin == modem_ctrl[1])
    else $error("rts pin not under software control");
  a_div_low: assert property (wr && paddr == 32'h8 && bank_ff[2:1] == 2'h1
    |=> baud_divisor[7:0] == $past(wbyte)) else $error("low divisor byte wrong");
  a_div_high: assert property (wr && paddr == 32'hc && bank_ff[2:1] == 2'h1
    |=> baud_divisor[15:8] == $past(wbyte)) else $error("high divisor byte wrong");
  a_lvl_closed: assert property (rd && (paddr == 32'h18 || paddr == 32'h1c)
    && bank_ff != 3'h1 && !(bank_ff[2:1] == 2'h2 && paddr == 32'h18)
    |-> pslverr) else $error("closed level counter answered");
  a_tx_space: assert property (rd && paddr == 32'h18 && bank_ff == 3'h1
    |-> !pslverr && prdata[7:0] == $past(tx_fifo_space)) else $error("tx space read wrong");
  a_rx_fill: assert property (rd && paddr == 32'h1c && bank_ff == 3'h1
    |-> !pslverr && prdata[7:0] == $past(rx_fifo_fill)) else $error("rx fill read wrong");
  a_status_read: assert property (rd && paddr == 32'h0
    |-> modem_status_read && prdata[7:0] == $past(modem_status_in))
    else $error("status read wrong");
  a_enh_latch: assert property (wr && paddr == 32'h8 && bank_ff[2:1] == 2'h0 && !efr_ff[4]
    |=> $stable(int_enable[7:4])) else $error("latched enable bits changed");
endmodule // ufc_checker
bind ufc_feature_ctrl ufc_checker chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .modem_status_in(modem_status_in),
  .modem_status_read(modem_status_read), .tx_fifo_space(tx_fifo_space),
  .rx_fifo_fill(rx_fifo_fill), .clear_to_send_in(clear_to_send_in), .tx_halt(tx_halt),
  .rts_pin(rts_pin), .baud_divisor(baud_divisor), .int_enable(int_enable),
  .modem_ctrl(modem_ctrl));

//--- ufc_modem_peer.sv
// serial-side peer: sends received characters, takes flow characters
`timescale 1ns/1ns
module ufc_modem_peer (
  input wire logic ref_clk,
  input wire logic tx_flow_valid,
  input wire logic [7:0] tx_flow_char,
  output logic tx_flow_ready,
  output logic rx_char_valid,
  output logic [7:0] rx_char,
  output logic clear_to_send_in
);
  logic slow;
  logic [7:0] got[$];
  initial begin
    slow = 1'b0;
    tx_flow_ready = 1'b0;
    rx_char_valid = 1'b0;
    rx_char = 8'h00;
    clear_to_send_in = 1'b0;
  end
  // slow mode stalls every other cycle so held characters are seen over waits
  always @(posedge ref_clk) begin
    if (tx_flow_valid && tx_flow_ready) got.push_back(tx_flow_char);
    tx_flow_ready <= slow ? !tx_flow_ready : 1'b1;
  end
  task send(input logic [7:0] c);
    @(posedge ref_clk);
    rx_char_valid <= 1'b1;
    rx_char <= c;
    @(posedge ref_clk);
    rx_char_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  task cts(input logic v);
    @(posedge ref_clk);
    clear_to_send_in <= v;
    @(negedge ref_clk);
  endtask
endmodule // ufc_modem_peer

//--- ufc_feature_ctrl_tb.sv
// self-checking testbench of the feature control block
`timescale 1ns/1ns
module ufc_feature_ctrl_tb;
  logic ref_clk, reset_n, clk_en, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, er, modem_status_read, tx_halt, rts_pin, rx_trigger_reached;
  logic [7:0] modem_status_in, tx_fifo_space, rx_fifo_fill, rx_trigger_level, rx_char;
  logic [15:0] baud_divisor;
  logic [7:0] int_enable, fifo_ctrl, modem_ctrl, tx_flow_char;
  logic special_char_seen, rx_on_match, rx_off_match, tx_send_on, tx_send_off;
  logic tx_flow_valid, tx_flow_ready, rx_char_valid, clear_to_send_in;
  int bad_count, compares;
  ufc_feature_ctrl dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modem_status_in(modem_status_in), .modem_status_read(modem_status_read),
    .tx_fifo_space(tx_fifo_space), .rx_fifo_fill(rx_fifo_fill),
    .rx_trigger_level(rx_trigger_level), .rx_char_valid(rx_char_valid), .rx_char(rx_char),
    .clear_to_send_in(clear_to_send_in), .tx_halt(tx_halt), .rts_pin(rts_pin),
    .rx_trigger_reached(rx_trigger_reached), .baud_divisor(baud_divisor),
    .int_enable(int_enable), .fifo_ctrl(fifo_ctrl), .modem_ctrl(modem_ctrl),
    .special_char_seen(special_char_seen), .rx_on_match(rx_on_match),
    .rx_off_match(rx_off_match), .tx_send_on(tx_send_on), .tx_send_off(tx_send_off),
    .tx_flow_valid(tx_flow_valid), .tx_flow_char(tx_flow_char), .tx_flow_ready(tx_flow_ready));
  ufc_modem_peer peer_u (.ref_clk(ref_clk), .tx_flow_valid(tx_flow_valid),
    .tx_flow_char(tx_flow_char), .tx_flow_ready(tx_flow_ready), .rx_char_valid(rx_char_valid),
    .rx_char(rx_char), .clear_to_send_in(clear_to_send_in));
  // ----
  // bus and compare tasks
  // ----
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!pready && n < 50);
    if (!pready) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge ref_clk);
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task rdc(input logic [31:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0, 4'hf);
    chk(rd, e);
    chk(er, ee);
  endtask
  // ----
  // scenarios
  // ----
  task t_banks;
    chk(baud_divisor, 32'h0);
    wr(32'h0, 32'h4);
    rdc(32'h8, 32'h0, 1'b0);
    rdc(32'h0, 32'h5a, 1'b0);
    wr(32'h0, 32'h2);
    wr(32'h8, 32'h34);
    wr(32'hc, 32'h12);
    chk(baud_divisor, 32'h1234);
    rdc(32'h8, 32'h34, 1'b0);
    rdc(32'h18, 32'h0, 1'b1);
    wr(32'h0, 32'h3);
    rdc(32'h1c, 32'h0, 1'b1);
    wr(32'h0, 32'h0);
    rdc(32'h18, 32'h0, 1'b1);
    wr(32'h0, 32'h1);
    tx_fifo_space <= 8'h7f;
    rx_fifo_fill <= 8'h03;
    rdc(32'h18, 32'h7f, 1'b0);
    wr(32'h18, 32'hff);
    rdc(32'h18, 32'h7f, 1'b0);
    rdc(32'h1c, 32'h3, 1'b0);
    wr(32'h0, 32'h6);
    rdc(32'h8, 32'h0, 1'b1);
  endtask
  task t_scratch;
    for (int i = 0; i < 3; i++) begin
      wr(32'h0, 2 * i);
      wr(32'h4, 32'ha5 + i);
      apb(1'b1, 32'h4, 32'h0, 4'h0);
      rdc(32'h4, 32'ha5 + i, 1'b0);
    end
    chk(baud_divisor, 32'h1234);
  endtask
  task t_hw_flow;
    wr(32'h0, 32'h4);
    wr(32'h8, 32'hc0);
    peer_u.cts(1'b1);
    chk(tx_halt, 1'b1);
    peer_u.cts(1'b0);
    chk(tx_halt, 1'b0);
    rx_trigger_level <= 8'h10;
    rx_fifo_fill <= 8'h11;
    repeat (3) @(negedge ref_clk);
    chk(rts_pin, 1'b1);
    chk(rx_trigger_reached, 1'b1);
    rdc(32'h8, 32'hc0, 1'b0);
    rx_fifo_fill <= 8'h0f;
    repeat (3) @(negedge ref_clk);
    chk(rts_pin, 1'b0);
    rdc(32'h8, 32'h80, 1'b0);
    wr(32'h8, 32'h10);
    wr(32'h0, 32'h0);
    wr(32'h10, 32'h2);
    chk(rts_pin, 1'b1);
    wr(32'h8, 32'hff);
    chk(int_enable, 32'hff);
    wr(32'h0, 32'h4);
    wr(32'h8, 32'h0);
    wr(32'h0, 32'h0);
    wr(32'h8, 32'h0);
    chk(int_enable, 32'hf0);
    wr(32'hc, 32'h3f);
    chk(fifo_ctrl, 32'h0f);
  endtask
  task t_special;
    wr(32'h0, 32'h4);
    wr(32'h8, 32'h0);
    wr(32'h18, 32'h13);
    wr(32'h8, 32'h20);
    peer_u.send(8'hc8);
    repeat (2) @(negedge ref_clk);
    chk(special_char_seen, 1'b0);
    peer_u.send(8'h13);
    repeat (2) @(negedge ref_clk);
    chk(special_char_seen, 1'b1);
    rdc(32'h14, 32'h0, 1'b0);
    wr(32'h0, 32'h0);
    rdc(32'h14, 32'h10, 1'b0);
    rdc(32'h14, 32'h0, 1'b0);
  endtask
  task t_tx_flow;
    wr(32'h0, 32'h4);
    wr(32'h8, 32'h0);
    wr(32'hc, 32'h51);
    wr(32'h14, 32'h11);
    wr(32'h18, 32'h93);
    wr(32'h8, 32'h0c);
    peer_u.slow = 1'b1;
    @(posedge ref_clk);
    tx_send_off <= 1'b1;
    @(posedge ref_clk);
    tx_send_off <= 1'b0;
    repeat (20) @(posedge ref_clk);
    wr(32'h8, 32'h08);
    @(posedge ref_clk);
    tx_send_on <= 1'b1;
    @(posedge ref_clk);
    tx_send_on <= 1'b0;
    repeat (20) @(negedge ref_clk);
    chk(peer_u.got.size(), 32'h3);
    chk(peer_u.got[0], 32'h11);
    chk(peer_u.got[1], 32'h93);
    chk(peer_u.got[2], 32'h51);
    chk(tx_flow_valid, 1'b0);
    // receive side: a pair must come first then second, a lone second is no match
    wr(32'h8, 32'h0f);
    peer_u.send(8'h11);
    peer_u.send(8'h93);
    @(negedge ref_clk);
    chk(rx_off_match, 1'b1);
    chk(rx_on_match, 1'b0);
    peer_u.send(8'h93);
    @(negedge ref_clk);
    chk(rx_off_match, 1'b0);
    wr(32'h8, 32'h0b);
    peer_u.send(8'h51);
    @(negedge ref_clk);
    chk(rx_on_match, 1'b1);
  endtask
  task results;
    if (bad_count == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // ----
  // clock, reset, sequence and timeout
  // ----
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    {reset_n, psel, penable, pwrite, tx_send_on, tx_send_off} = 6'h0;
    clk_en = 1'b1;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    modem_status_in = 8'h5a;
    {tx_fifo_space, rx_fifo_fill, rx_trigger_level} = 24'h0;
    bad_count = 0;
    compares = 0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_banks;
    t_scratch;
    t_hw_flow;
    t_special;
    t_tx_flow;
    results;
  end
  // a hang costs at most this many cycles; the sequence needs well under a thousand
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    results;
  end
endmodule // ufc_feature_ctrl_tb
